// >>> hw/aodr_pkg.sv
// Constants and carrier types for the accelerometer output data registers
package aodr_pkg;

    // Host register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Sample layout
    localparam int SAMPLE_W = 12;
    localparam int NUM_AXES = 3;
    localparam int SIGN_BIT = 11;
    localparam int NIBBLE_W = 4;

    // Register offsets
    localparam logic [7:0] OFS_X_LOW = 8'h04;
    localparam logic [7:0] OFS_X_HIGH = 8'h05;
    localparam logic [7:0] OFS_Y_LOW = 8'h06;
    localparam logic [7:0] OFS_Y_HIGH = 8'h07;
    localparam logic [7:0] OFS_Z_LOW = 8'h08;
    localparam logic [7:0] OFS_Z_HIGH = 8'h09;
    localparam logic [7:0] OFS_QUEUE_STATUS = 8'h0B;

    // Reset and fill values
    localparam logic [7:0] QUEUE_STATUS_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [3:0] BE_LOW_FILL = 4'h0;
    localparam logic BYTE_ORDER_RESET = 1'b0;

    // Queue status fields and limits
    localparam int WMRK_BIT = 7;
    localparam int OVF_BIT = 6;
    localparam int CNT_W = 6;
    localparam int MODE_W = 2;
    localparam logic [5:0] QUEUE_DEPTH = 6'h20;
    localparam logic [1:0] MODE_DISABLED = 2'h0;

    // Latched XYZ triplet; axis 0 is X
    typedef struct packed {
        logic [NUM_AXES-1:0][SAMPLE_W-1:0] axis;
    } aodr_sample_t;

    // Queue status byte, bit 7 down to bit 0
    typedef struct packed {
        logic wmrk;
        logic ovf;
        logic [CNT_W-1:0] cnt;
    } aodr_queue_status_t;

    // Register access request from the serial interface front end
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } aodr_host_req_t;

endpackage

// >>> hw/aodr_queue_status.sv
// Sample queue occupancy count, overflow and watermark status byte
`timescale 1ns/1ns
module aodr_queue_status import aodr_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Queue configuration
    input wire logic [MODE_W-1:0] queueMode,
    input wire logic [CNT_W-1:0] watermarkLevel,
    // Queue events, one-cycle pulses
    input wire logic queuePush,
    input wire logic queuePop,
    input wire logic queueFlush,
    // Status view
    output aodr_queue_status_t queueStatus
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic ovf;
        aodr_queue_status_t view;
    } aodr_qs_state_t;

    aodr_qs_state_t state_q;
    aodr_qs_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (queueMode == MODE_DISABLED || queueFlush) begin
            state_d.cnt = '0;
            state_d.ovf = 1'b0;
        end else if (queuePush && !queuePop) begin
            if (state_q.cnt == QUEUE_DEPTH) begin
                state_d.ovf = 1'b1;
            end else begin
                state_d.cnt = state_q.cnt + 6'h01;
            end
        end else if (queuePop && !queuePush) begin
            state_d.ovf = 1'b0;
            if (state_q.cnt != 6'h00) begin
                state_d.cnt = state_q.cnt - 6'h01;
            end
        end else if (queuePop && queuePush) begin
            // Slot freed in the same cycle, so no overflow
            state_d.ovf = 1'b0;
        end
        if (queueMode == MODE_DISABLED) begin
            state_d.view = QUEUE_STATUS_RESET;
        end else begin
            state_d.view.cnt = state_d.cnt;
            state_d.view.ovf = state_d.ovf;
            state_d.view.wmrk = (watermarkLevel != 6'h00) && (state_d.cnt >= watermarkLevel);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign queueStatus = state_q.view;

endmodule

// >>> hw/aodr_regs.sv
// Accelerometer XYZ output data registers and queue status read view
//
// Functional notes
// - Axis pairs at 04h, 06h, 08h
// - Little-endian: low bits 7:0, high 11:8
// - Big-endian: low 11:4, high 3:0 then zeros
// - Axis bytes read-only; writes change nothing
// - Queue mode 00b: status reads 00h
// - Status: watermark 7, overflow 6, count 5:0
// - Little-endian sign fill copies bit 11
// - Latch XYZ with ready flag; axis byte reads clear
// - Select one is big-endian; resets little-endian
// - Count stops at 32; push sets overflow
`timescale 1ns/1ns
module aodr_regs import aodr_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // New conversion result
    input wire aodr_sample_t newSample,
    input wire logic sampleStrobe,
    // Configuration levels from the config registers
    input wire logic byteOrderSelect,
    input wire logic [MODE_W-1:0] queueMode,
    input wire logic [CNT_W-1:0] watermarkLevel,
    // Queue events
    input wire logic queuePush,
    input wire logic queuePop,
    input wire logic queueFlush,
    // Host register port
    input wire aodr_host_req_t hostReq,
    output logic [DATA_W-1:0] rdData,
    output logic rdValid,
    // Status
    output logic sampleReadyFlag
);

    // Which readable byte the address selects
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_X_LOW = 3'h1,
        SEL_X_HIGH = 3'h2,
        SEL_Y_LOW = 3'h3,
        SEL_Y_HIGH = 3'h4,
        SEL_Z_LOW = 3'h5,
        SEL_Z_HIGH = 3'h6,
        SEL_STATUS = 3'h7
    } aodr_reg_sel_t;

    typedef struct packed {
        aodr_sample_t held;
        logic bigEndian;
        logic ready;
        logic [DATA_W-1:0] rdData;
        logic rdValid;
    } aodr_state_t;

    aodr_state_t state_q;
    aodr_state_t state_d;
    aodr_queue_status_t queueStatus;
    aodr_reg_sel_t regSel;
    wire logic [NUM_AXES-1:0][DATA_W-1:0] lowByte;
    wire logic [NUM_AXES-1:0][DATA_W-1:0] highByte;
    logic [DATA_W-1:0] readByte;
    logic axisByte;
    logic axisRead;

    aodr_queue_status u_queue_status (
        .clk(clk),
        .rst(rst),
        .queueMode(queueMode),
        .watermarkLevel(watermarkLevel),
        .queuePush(queuePush),
        .queuePop(queuePop),
        .queueFlush(queueFlush),
        .queueStatus(queueStatus)
    );

    // Byte at the lower address of an axis pair
    function automatic logic [DATA_W-1:0] packLow(
        input logic [SAMPLE_W-1:0] s,
        input logic bigEnd
    );
        logic [DATA_W-1:0] b;
        if (bigEnd) begin
            b = s[SAMPLE_W-1:NIBBLE_W];
        end else begin
            b = s[DATA_W-1:0];
        end
        return b;
    endfunction

    // Byte at the upper address; little-endian keeps a signed 16-bit view
    function automatic logic [DATA_W-1:0] packHigh(
        input logic [SAMPLE_W-1:0] s,
        input logic bigEnd
    );
        logic [DATA_W-1:0] b;
        if (bigEnd) begin
            b = {s[NIBBLE_W-1:0], BE_LOW_FILL};
        end else begin
            b = {{NIBBLE_W{s[SIGN_BIT]}}, s[SAMPLE_W-1:DATA_W]};
        end
        return b;
    endfunction

    // Byte packing per axis for the current order
    genvar gi;
    generate
        for (gi = 0; gi < NUM_AXES; gi++) begin : g_axis
            assign lowByte[gi] = packLow(state_q.held.axis[gi], state_q.bigEndian);
            assign highByte[gi] = packHigh(state_q.held.axis[gi], state_q.bigEndian);
        end
    endgenerate

    // Axis bytes sit at consecutive addresses, low byte first
    always_comb begin
        case (hostReq.addr)
            OFS_X_LOW: begin
                regSel = SEL_X_LOW;
                axisByte = 1'b1;
            end
            OFS_X_HIGH: begin
                regSel = SEL_X_HIGH;
                axisByte = 1'b1;
            end
            OFS_Y_LOW: begin
                regSel = SEL_Y_LOW;
                axisByte = 1'b1;
            end
            OFS_Y_HIGH: begin
                regSel = SEL_Y_HIGH;
                axisByte = 1'b1;
            end
            OFS_Z_LOW: begin
                regSel = SEL_Z_LOW;
                axisByte = 1'b1;
            end
            OFS_Z_HIGH: begin
                regSel = SEL_Z_HIGH;
                axisByte = 1'b1;
            end
            OFS_QUEUE_STATUS: begin
                regSel = SEL_STATUS;
                axisByte = 1'b0;
            end
            default: begin
                regSel = SEL_NONE;
                axisByte = 1'b0;
            end
        endcase
    end

    // Unmapped addresses read a fixed filler
    always_comb begin
        case (regSel)
            SEL_X_LOW: begin
                readByte = lowByte[0];
            end
            SEL_X_HIGH: begin
                readByte = highByte[0];
            end
            SEL_Y_LOW: begin
                readByte = lowByte[1];
            end
            SEL_Y_HIGH: begin
                readByte = highByte[1];
            end
            SEL_Z_LOW: begin
                readByte = lowByte[2];
            end
            SEL_Z_HIGH: begin
                readByte = highByte[2];
            end
            SEL_STATUS: begin
                readByte = queueStatus;
            end
            default: begin
                readByte = UNMAPPED_READ;
            end
        endcase
    end

    assign axisRead = hostReq.rd && axisByte;

    always_comb begin
        state_d = state_q;
        state_d.rdValid = hostReq.rd;
        // Applied one cycle late, which keeps a read in flight consistent
        state_d.bigEndian = byteOrderSelect;
        if (hostReq.rd) begin
            state_d.rdData = readByte;
        end
        // Writes are not decoded at all, so a write never changes held data
        if (axisRead) begin
            state_d.ready = 1'b0;
        end
        // New sample wins over a clearing read in the same cycle
        if (sampleStrobe) begin
            state_d.held = newSample;
            state_d.ready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q.held <= '0;
            state_q.bigEndian <= BYTE_ORDER_RESET;
            state_q.ready <= 1'b0;
            state_q.rdData <= '0;
            state_q.rdValid <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdData = state_q.rdData;
    assign rdValid = state_q.rdValid;
    assign sampleReadyFlag = state_q.ready;

endmodule

// >>> verif/aodr_host_model.sv
// Host side register reader and writer
`timescale 1ns/1ns
module aodr_host_model import aodr_pkg::*; (
    // Clock
    input wire logic clk,
    // Register request
    output aodr_host_req_t hostReq
);
    initial hostReq = '0;
    task automatic access(input logic [7:0] a, input logic r, input logic w, input logic [7:0] d);
        hostReq.addr = a;
        hostReq.rd = r;
        hostReq.wr = w;
        hostReq.wdata = d;
        @(posedge clk);
        #1;
    endtask
    // Address scrambled while idle so stale values are never relied on
    task automatic idle();
        hostReq = {~hostReq.addr, 2'b00, ~hostReq.wdata};
        @(posedge clk);
        #1;
    endtask
endmodule

// >>> verif/aodr_regs_asserts.sv
// Port-level checks for the output data registers
`timescale 1ns/1ns
module aodr_regs_asserts import aodr_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire aodr_sample_t newSample,
    input wire logic sampleStrobe,
    input wire logic byteOrderSelect,
    input wire logic [MODE_W-1:0] queueMode,
    input wire aodr_host_req_t hostReq,
    // Outputs
    input wire logic [DATA_W-1:0] rdData,
    input wire logic rdValid,
    input wire logic sampleReadyFlag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence beRead;
        byteOrderSelect [*2] ##0 (hostReq.rd && hostReq.addr inside {8'h05, 8'h07, 8'h09});
    endsequence
    sequence leHighRead;
        !byteOrderSelect [*2] ##0 (hostReq.rd && hostReq.addr inside {8'h05, 8'h07, 8'h09});
    endsequence
    chk_read_answer: assert property (hostReq.rd |=> rdValid) else $error("no answer");
    chk_no_spurious: assert property (!hostReq.rd |=> !rdValid) else $error("stray valid");
    chk_ready_set: assert property (sampleStrobe |=> sampleReadyFlag) else $error("no ready");
    chk_ready_clear: assert property (hostReq.rd && hostReq.addr inside {[8'h04:8'h09]}
        && !sampleStrobe |=> !sampleReadyFlag) else $error("ready kept");
    chk_ready_cause: assert property (!sampleStrobe |=> !$rose(sampleReadyFlag))
        else $error("ready without sample");
    chk_be_fill: assert property (beRead |=> rdData[3:0] == BE_LOW_FILL)
        else $error("low nibble nonzero");
    chk_le_sign: assert property (leHighRead |=> rdData[7:4] == {4{rdData[3]}})
        else $error("sign fill wrong");
    chk_queue_off: assert property ((queueMode == MODE_DISABLED) [*2] ##0
        (hostReq.rd && hostReq.addr == OFS_QUEUE_STATUS) |=> rdData == 8'h00)
        else $error("status not zero");
endmodule
bind aodr_regs aodr_regs_asserts u_aodr_regs_asserts (.clk, .rst, .newSample, .sampleStrobe,
    .byteOrderSelect, .queueMode, .hostReq, .rdData, .rdValid, .sampleReadyFlag);

// >>> verif/aodr_regs_test.sv
// Self-checking bench for the output data registers
`timescale 1ns/1ns
module aodr_regs_test import aodr_pkg::*; ;
    logic clk = 0, rst = 1, strobe = 0, order = 0, push = 0, pop = 0, flush = 0;
    logic [1:0] mode = 2'h1;
    logic [5:0] wm = 6'h04;
    logic [63:0] rnd;
    logic [7:0] rdData, expQ[$];
    logic rdValid, flag;
    aodr_sample_t held = '0;
    aodr_host_req_t hostReq;
    int miscompares = 0, samplesChecked = 0, seed = 15;
    always #20 clk = ~clk;
    aodr_host_model u_aodr_host_model (.clk(clk), .hostReq(hostReq));
    aodr_regs u_aodr_regs (.clk(clk), .rst(rst), .newSample(held), .sampleStrobe(strobe),
        .byteOrderSelect(order), .queueMode(mode), .watermarkLevel(wm), .queuePush(push),
        .queuePop(pop), .queueFlush(flush), .hostReq(hostReq), .rdData(rdData),
        .rdValid(rdValid), .sampleReadyFlag(flag));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        samplesChecked++;
        if (e !== g) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkFlag(logic e, logic g);
        samplesChecked++;
        if (e !== g) begin
            miscompares++;
            $display("CHECK FAILED flag expected %b seen %b", e, g);
        end
    endtask
    // A valid with no pending note is itself a mismatch
    always @(negedge clk) begin
        if (rdValid === 1'b1 && expQ.size() == 0) begin
            chk("rdValid", 8'h00, 8'h01);
        end else if (rdValid === 1'b1) begin
            chk("rdData", expQ.pop_front(), rdData);
        end
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        u_aodr_host_model.access(a, 1'b1, 1'b0, 8'h00);
    endtask
    function automatic logic [7:0] pk(logic [11:0] v, logic hi, logic be);
        if (be) return hi ? {v[3:0], 4'h0} : v[11:4];
        return hi ? {{4{v[11]}}, v[11:8]} : v[7:0];
    endfunction
    task stopTest;
        // Reads that never got an answer count against the run
        if (expQ.size() != 0) miscompares++;
        $display("compared %0d miscompares %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #40000;
        miscompares++;
        stopTest();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 0;
        rd(8'h0B, 8'h00);
        rd(8'h0A, 8'h00);
        rd(8'h0C, 8'h00);
        u_aodr_host_model.idle();
        for (int k = 0; k < 6; k++) begin
            rnd = {$random(seed), $random(seed)};
            held = rnd[35:0];
            strobe = 1;
            order = k[0];
            @(posedge clk);
            #1 strobe = 0;
            chkFlag(1'b1, flag);
            u_aodr_host_model.access(8'h04 + 8'(k), 1'b0, 1'b1, rnd[63:56]);
            for (int i = 0; i < 6; i++) rd(8'h04 + 8'(i), pk(held.axis[i/2], i[0], k[0]));
            u_aodr_host_model.idle();
            chkFlag(1'b0, flag);
        end
        push = 1;
        repeat (33) @(posedge clk);
        #1 push = 0;
        rd(8'h0B, 8'hE0);
        pop = 1;
        u_aodr_host_model.idle();
        pop = 0;
        rd(8'h0B, 8'h9F);
        flush = 1;
        u_aodr_host_model.idle();
        flush = 0;
        rd(8'h0B, 8'h00);
        push = 1;
        repeat (3) u_aodr_host_model.idle();
        push = 0;
        mode = 2'h0;
        u_aodr_host_model.idle();
        u_aodr_host_model.idle();
        rd(8'h0B, 8'h00);
        repeat (3) u_aodr_host_model.idle();
        stopTest();
    end
endmodule
